/* design/tcc_pkg.sv */
// Package of register map, field positions and codes for the timer channel
package tcc_pkg;
	localparam logic [7:0] TCC_OFS_ENABLE = 8'h00;
	localparam logic [7:0] TCC_OFS_RUN = 8'h04;
	localparam logic [7:0] TCC_OFS_MODE = 8'h08;
	localparam logic [7:0] TCC_OFS_FFCTRL = 8'h0C;
	localparam logic [7:0] TCC_OFS_STATUS = 8'h10;
	localparam logic [7:0] TCC_OFS_MASK = 8'h14;
	localparam logic [7:0] TCC_OFS_COUNT = 8'h18;
	localparam logic [7:0] TCC_OFS_CMP0 = 8'h1C;
	localparam logic [7:0] TCC_OFS_CMP1 = 8'h20;
	localparam logic [7:0] TCC_OFS_CAP0 = 8'h24;
	localparam logic [7:0] TCC_OFS_CAP1 = 8'h28;
	localparam int TCC_WIDTH = 16;
	// Enable register
	localparam int TCC_EN_BIT = 0;
	// Run register
	localparam int TCC_RUN_CNT_BIT = 0;
	localparam int TCC_RUN_PRE_BIT = 2;
	// Mode register
	localparam int TCC_MOD_CLK_LSB = 0;
	localparam int TCC_MOD_CPM_LSB = 4;
	localparam int TCC_MOD_CLE_BIT = 8;
	localparam logic [2:0] TCC_CLK_EXT = 3'h0;
	localparam logic [2:0] TCC_CLK_T1 = 3'h1;
	localparam logic [2:0] TCC_CLK_T4 = 3'h2;
	localparam logic [2:0] TCC_CLK_T16 = 3'h3;
	localparam logic [2:0] TCC_CPM_OFF = 3'h0;
	localparam logic [2:0] TCC_CPM_PIN = 3'h2;
	localparam logic [2:0] TCC_CPM_PEER = 3'h3;
	// Flip-flop control register
	localparam int TCC_FF_INIT_LSB = 0;
	localparam int TCC_FF_E0_BIT = 2;
	localparam int TCC_FF_E1_BIT = 3;
	localparam int TCC_FF_C0_BIT = 4;
	localparam int TCC_FF_C1_BIT = 5;
	localparam logic [1:0] TCC_FFC_INVERT = 2'h0;
	localparam logic [1:0] TCC_FFC_SET = 2'h1;
	localparam logic [1:0] TCC_FFC_CLEAR = 2'h2;
	localparam logic [1:0] TCC_FFC_NONE = 2'h3;
	// Status and mask bits
	localparam int TCC_ST_M0_BIT = 0;
	localparam int TCC_ST_M1_BIT = 1;
	localparam int TCC_ST_OF_BIT = 2;
	localparam int TCC_ST_CP0_BIT = 3;
	localparam int TCC_ST_CP1_BIT = 4;
	// Reset values
	localparam logic [5:0] TCC_FFCTRL_RST = 6'h03;
	localparam logic [8:0] TCC_MODE_RST = 9'h000;
	localparam logic [2:0] TCC_MASK_RST = 3'h0;
	// Prescaler taps: T1 = pclk/2, T4 = pclk/8, T16 = pclk/32
	localparam int TCC_PRE_T1_BIT = 0;
	localparam int TCC_PRE_T4_BIT = 2;
	localparam int TCC_PRE_T16_BIT = 4;
	localparam int TCC_PRE_WIDTH = 5;
endpackage

/* design/tcc_edge_sync.sv */
// Two-flop synchroniser with rising and falling edge pulses
module tcc_edge_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous level in
	input wire logic async_in,
	// Synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= async_in;
			sync <= meta;
			last <= sync;
		end
	end

	assign level = sync;
	assign rise = sync & ~last;
	assign fall = ~sync & last;
endmodule

/* design/tcc_timer_channel.sv */
// Timer channel with capture, compare, output flip-flop and APB registers
// Overview of operation
// - 16-bit counter, prescaled or external event
// - Select 000 counts external pin rising edges
// - Select 001 counts first prescaler output
// - Code 011 captures on companion flip-flop edges
// - Code 010 captures on pin edges
// - Capture 1 raises capture-1 request
// - Capture 0 raises capture-0 request
// - Both match enables toggle on each match
// - From zero, match0 sets, match1 clears
// - Pattern 0011 toggles on matches only
// - Init field 10 forces flip-flop low
// - Enables 00 stop match toggling
// - Mask bits suppress overflow, match1, match0
// - Init field 00 inverts, 01 sets, 10 clears
// - Any unmasked compare match or overflow raises match request
// - Flip-flop drives timer output pin
module tcc_timer_channel
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External pins
	input wire logic external_input_pin,
	input wire logic peer_flip_flop,
	output logic timer_output_pin,
	// Interrupt requests
	output logic match_irq,
	output logic capture0_irq,
	output logic capture1_irq
);
	import tcc_pkg::*;

	logic channel_enable;
	logic prescaler_run;
	logic counter_run;
	logic [2:0] count_clock_sel;
	logic [2:0] capture_timing_sel;
	logic clear_on_match1;
	logic [5:0] flip_flop_control;
	logic [2:0] irq_mask;
	logic [4:0] status;
	logic [TCC_WIDTH-1:0] counter;
	logic [TCC_WIDTH-1:0] compare_reg_0;
	logic [TCC_WIDTH-1:0] compare_reg_1;
	logic [TCC_WIDTH-1:0] capture_reg_0;
	logic [TCC_WIDTH-1:0] capture_reg_1;
	logic output_flip_flop;
	logic [TCC_PRE_WIDTH-1:0] prescaler;
	logic [TCC_PRE_WIDTH-1:0] next_prescaler;
	logic pin_level;
	logic pin_rise;
	logic pin_fall;
	logic peer_rise;
	logic peer_fall;
	logic tick;
	logic active;
	logic match0;
	logic match1;
	logic overflow;
	logic capt0;
	logic capt1;
	logic toggle;
	logic wr_en;
	logic rd_en;
	logic ff_write;

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= TCC_OFS_CAP1);
	endfunction

	tcc_edge_sync u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(external_input_pin),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	tcc_edge_sync u_peer_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(peer_flip_flop),
		.level(),
		.rise(peer_rise),
		.fall(peer_fall)
	);

	// Zero-wait APB: every access completes in its first access cycle
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign ff_write = wr_en && addr_hit(paddr, TCC_OFS_FFCTRL);

	assign active = channel_enable & prescaler_run & counter_run;

	// Prescaler counts only while its run bit is set; cleared when stopped
	assign next_prescaler = prescaler + {{(TCC_PRE_WIDTH-1){1'b0}}, 1'b1};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler <= '0;
		end else if (channel_enable && prescaler_run) begin
			prescaler <= next_prescaler;
		end else begin
			prescaler <= '0;
		end
	end

	// One-cycle tick when the selected tap bit falls
	always_comb begin
		case (count_clock_sel)
			TCC_CLK_EXT: tick = pin_rise;
			TCC_CLK_T1: tick = prescaler_run && (prescaler[TCC_PRE_T1_BIT:0] == '1);
			TCC_CLK_T4: tick = prescaler_run && (prescaler[TCC_PRE_T4_BIT:0] == '1);
			TCC_CLK_T16: tick = prescaler_run && (prescaler[TCC_PRE_T16_BIT:0] == '1);
			default: tick = prescaler_run && (prescaler == '1);
		endcase
	end

	assign match0 = active && (counter == compare_reg_0);
	assign match1 = active && (counter == compare_reg_1);
	assign overflow = active && tick && (counter == '1);
	assign capt0 = active && ((capture_timing_sel == TCC_CPM_PIN && pin_rise) ||
		(capture_timing_sel == TCC_CPM_PEER && peer_rise));
	assign capt1 = active && ((capture_timing_sel == TCC_CPM_PIN && pin_fall) ||
		(capture_timing_sel == TCC_CPM_PEER && peer_fall));

	// Up-counter; cleared when stopped so a restart begins at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter <= '0;
		end else if (!(channel_enable && counter_run)) begin
			counter <= '0;
		end else if (active && tick) begin
			if (clear_on_match1 && counter == compare_reg_1) begin
				counter <= '0;
			end else begin
				counter <= counter + 16'h0001;
			end
		end
	end

	// Match detection is level based; edge it so one match toggles once
	logic match0_seen;
	logic match1_seen;
	logic match0_evt;
	logic match1_evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match0_seen <= 1'b0;
			match1_seen <= 1'b0;
		end else begin
			match0_seen <= match0;
			match1_seen <= match1;
		end
	end

	assign match0_evt = match0 & ~match0_seen;
	assign match1_evt = match1 & ~match1_seen;

	// Capture registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_reg_0 <= '0;
			capture_reg_1 <= '0;
		end else begin
			if (capt0) begin
				capture_reg_0 <= counter;
			end
			if (capt1) begin
				capture_reg_1 <= counter;
			end
		end
	end

	// Toggle sources gated by their enables
	assign toggle = (match0_evt && flip_flop_control[TCC_FF_E0_BIT]) ^
		(match1_evt && flip_flop_control[TCC_FF_E1_BIT]) ^
		(capt0 && flip_flop_control[TCC_FF_C0_BIT]) ^
		(capt1 && flip_flop_control[TCC_FF_C1_BIT]);

	// Software init wins over a same-cycle toggle
	logic next_flip_flop;

	always_comb begin
		next_flip_flop = output_flip_flop ^ toggle;
		if (ff_write) begin
			case (pwdata[TCC_FF_INIT_LSB +: 2])
				TCC_FFC_INVERT: next_flip_flop = ~output_flip_flop;
				TCC_FFC_SET: next_flip_flop = 1'b1;
				TCC_FFC_CLEAR: next_flip_flop = 1'b0;
				default: next_flip_flop = output_flip_flop ^ toggle;
			endcase
		end
	end

	// Pin copy loads the same next value, so it never lags a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_flip_flop <= 1'b0;
			timer_output_pin <= 1'b0;
		end else begin
			output_flip_flop <= next_flip_flop;
			timer_output_pin <= next_flip_flop;
		end
	end

	// Status flags: a read clears only the bits it returned; set wins
	logic [4:0] events;
	assign events = {capt1, capt0, overflow, match1_evt, match0_evt};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
		end else if (rd_en && addr_hit(paddr, TCC_OFS_STATUS)) begin
			status <= (status & ~prdata[4:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	// Request pulses, one per event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_irq <= 1'b0;
			capture0_irq <= 1'b0;
			capture1_irq <= 1'b0;
		end else begin
			match_irq <= (match0_evt && !irq_mask[TCC_ST_M0_BIT]) ||
				(match1_evt && !irq_mask[TCC_ST_M1_BIT]) ||
				(overflow && !irq_mask[TCC_ST_OF_BIT]);
			capture0_irq <= capt0;
			capture1_irq <= capt1;
		end
	end

	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_enable <= 1'b0;
			prescaler_run <= 1'b0;
			counter_run <= 1'b0;
			{clear_on_match1, capture_timing_sel, count_clock_sel} <= {TCC_MODE_RST[8], TCC_MODE_RST[6:4],
				TCC_MODE_RST[2:0]};
			flip_flop_control <= TCC_FFCTRL_RST;
			irq_mask <= TCC_MASK_RST;
			compare_reg_0 <= '0;
			compare_reg_1 <= '0;
		end else if (wr_en) begin
			if (addr_hit(paddr, TCC_OFS_ENABLE)) begin
				channel_enable <= pwdata[TCC_EN_BIT];
			end
			if (addr_hit(paddr, TCC_OFS_RUN)) begin
				prescaler_run <= pwdata[TCC_RUN_PRE_BIT];
				counter_run <= pwdata[TCC_RUN_CNT_BIT];
			end
			if (addr_hit(paddr, TCC_OFS_MODE)) begin
				count_clock_sel <= pwdata[TCC_MOD_CLK_LSB +: 3];
				capture_timing_sel <= pwdata[TCC_MOD_CPM_LSB +: 3];
				clear_on_match1 <= pwdata[TCC_MOD_CLE_BIT];
			end
			if (ff_write) begin
				// Init field is an action, not stored; it reads back as 11
				flip_flop_control <= {pwdata[TCC_FF_C1_BIT:TCC_FF_E0_BIT], TCC_FFC_NONE};
			end
			if (addr_hit(paddr, TCC_OFS_MASK)) begin
				irq_mask <= pwdata[2:0];
			end
			if (addr_hit(paddr, TCC_OFS_CMP0)) begin
				compare_reg_0 <= pwdata[TCC_WIDTH-1:0];
			end
			if (addr_hit(paddr, TCC_OFS_CMP1)) begin
				compare_reg_1 <= pwdata[TCC_WIDTH-1:0];
			end
		end
	end

	// Read data registered in the setup cycle, valid in the access cycle
	logic [31:0] next_prdata;

	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			TCC_OFS_ENABLE: next_prdata[TCC_EN_BIT] = channel_enable;
			TCC_OFS_RUN: begin
				next_prdata[TCC_RUN_PRE_BIT] = prescaler_run;
				next_prdata[TCC_RUN_CNT_BIT] = counter_run;
			end
			TCC_OFS_MODE: next_prdata[8:0] = {clear_on_match1, 1'b0, capture_timing_sel, 1'b0, count_clock_sel};
			TCC_OFS_FFCTRL: next_prdata[5:0] = flip_flop_control;
			TCC_OFS_STATUS: next_prdata[4:0] = status;
			TCC_OFS_MASK: next_prdata[2:0] = irq_mask;
			TCC_OFS_COUNT: next_prdata[TCC_WIDTH-1:0] = counter;
			TCC_OFS_CMP0: next_prdata[TCC_WIDTH-1:0] = compare_reg_0;
			TCC_OFS_CMP1: next_prdata[TCC_WIDTH-1:0] = compare_reg_1;
			TCC_OFS_CAP0: next_prdata[TCC_WIDTH-1:0] = capture_reg_0;
			TCC_OFS_CAP1: next_prdata[TCC_WIDTH-1:0] = capture_reg_1;
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
			pready <= psel && !penable;
			pslverr <= psel && !penable && !is_mapped(paddr);
		end
	end
endmodule

/* testbench/tcc_chk.sv */
// Port assertions for the timer channel
module tcc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic match_irq,
	input wire logic capture0_irq,
	input wire logic capture1_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence bad_s;
		setup_s ##0 (paddr > 8'h28 || paddr[1:0] != 2'h0);
	endsequence
	sequence good_s;
		setup_s ##0 (paddr <= 8'h28 && paddr[1:0] == 2'h0);
	endsequence
	a_ready_after_setup: assert property (setup_s |=> pready) else $error("pready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
	a_ready_has_cause: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
	a_err_unmapped: assert property (bad_s |=> pslverr && pready) else $error("unmapped access not refused");
	a_err_mapped: assert property (good_s |=> !pslverr) else $error("mapped access refused");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata moved outside read setup");
	a_cap0_pulse: assert property (capture0_irq |=> !capture0_irq) else $error("capture0 request too long");
	a_cap1_pulse: assert property (capture1_irq |=> !capture1_irq) else $error("capture1 request too long");
	a_match_pulse: assert property (match_irq |=> !match_irq) else $error("match request too long");
endmodule

bind tcc_timer_channel tcc_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.match_irq(match_irq), .capture0_irq(capture0_irq), .capture1_irq(capture1_irq));

/* testbench/tcc_pulse_src.sv */
// External pulse source and companion flip-flop model
module tcc_pulse_src (
	input wire logic pclk,
	output logic pin,
	output logic peer
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pin = 1'h0;
		peer = 1'h0;
	end
	// Whole cycles only, so the synchronisers never see a runt
	task automatic pulse(input int hi, input int lo);
		@(posedge pclk);
		pin <= 1'h1;
		repeat (hi) @(posedge pclk);
		pin <= 1'h0;
		repeat (lo) @(posedge pclk);
	endtask
	task automatic set_peer(input logic v);
		@(posedge pclk);
		peer <= v;
		repeat (6) @(posedge pclk);
	endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the timer channel
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tcc_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, c0v, c1v;
	logic [15:0] dif;
	logic pready, pslverr, pin, peer, tout, m_irq, c0_irq, c1_irq, err_seen, tprev = 1'h0;
	int err_total = 0, compares = 0, m_cnt = 0, c0_cnt = 0, c1_cnt = 0, t_cnt = 0;
	int seed = 32'h2e7a00d8, w, a, b, base, c0b, c1b;
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		tprev <= tout;
		if (tout !== tprev) t_cnt <= t_cnt + 1;
		if (m_irq === 1'h1) m_cnt <= m_cnt + 1;
		if (c0_irq === 1'h1) c0_cnt <= c0_cnt + 1;
		if (c1_irq === 1'h1) c1_cnt <= c1_cnt + 1;
	end
	tcc_timer_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_input_pin(pin), .peer_flip_flop(peer), .timer_output_pin(tout),
		.match_irq(m_irq), .capture0_irq(c0_irq), .capture1_irq(c1_irq));
	tcc_pulse_src src (.pclk(pclk), .pin(pin), .peer(peer));
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic is_wr, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= is_wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			err_total++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'h1, ad, d);
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'h0, ad, 32'h0);
		check(rd, exp);
	endtask
	task automatic wait_out(input logic v);
		int n;
		n = 0;
		while (tout !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			report_and_stop();
		end
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		rchk(TCC_OFS_FFCTRL, 32'h3);
		rchk(TCC_OFS_MODE, 32'h0);
		rchk(TCC_OFS_MASK, 32'h0);
		rchk(8'h2C, 32'h0);
		check(err_seen, 32'h1);
		$display("test reset done");
		// Pulse generation with only the compare-1 request unmasked
		a = 2 + ($random(seed) & 15);
		b = a + 3 + ($random(seed) & 15);
		wr(TCC_OFS_CMP0, 32'(a));
		wr(TCC_OFS_CMP1, 32'(b));
		wr(TCC_OFS_FFCTRL, 32'h01);
		@(posedge pclk);
		check(tout, 32'h1);
		wr(TCC_OFS_FFCTRL, 32'h0E);
		wr(TCC_OFS_MODE, 32'h101);
		wr(TCC_OFS_MASK, 32'h5);
		wr(TCC_OFS_ENABLE, 32'h1);
		check(tout, 32'h0);
		base = m_cnt;
		wr(TCC_OFS_RUN, 32'h5);
		wait_out(1'h1);
		repeat (3) @(posedge pclk);
		check(m_cnt - base, 32'h0);
		wait_out(1'h0);
		repeat (3) @(posedge pclk);
		check(m_cnt - base, 32'h1);
		wait_out(1'h1);
		wait_out(1'h0);
		repeat (3) @(posedge pclk);
		check(m_cnt - base, 32'h2);
		wr(TCC_OFS_FFCTRL, 32'h03);
		// A toggle launched just before the write is still being counted
		repeat (2) @(posedge pclk);
		base = t_cnt;
		repeat (4 * b + 8) @(posedge pclk);
		check(t_cnt - base, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(TCC_OFS_FFCTRL, 32'((8'h46 >> (2 * i)) & 8'h03));
			repeat (2) @(posedge pclk);
			check(tout, 32'((4'hA >> i) & 4'h1));
		end
		$display("test compare done");
		wr(TCC_OFS_RUN, 32'h0);
		wr(TCC_OFS_RUN, 32'h1);
		repeat (20) @(posedge pclk);
		rchk(TCC_OFS_COUNT, 32'h0);
		// High width on the pin, difference taken modulo the counter range
		wr(TCC_OFS_MODE, 32'h021);
		wr(TCC_OFS_RUN, 32'h5);
		c0b = c0_cnt;
		c1b = c1_cnt;
		w = 8 + ($random(seed) & 63);
		src.pulse(w, 8);
		repeat (6) @(posedge pclk);
		apb(1'h0, TCC_OFS_CAP0, 32'h0);
		c0v = rd;
		apb(1'h0, TCC_OFS_CAP1, 32'h0);
		c1v = rd;
		dif = c1v[15:0] - c0v[15:0];
		check(32'(dif >= w / 2 - 1 && dif <= w / 2 + 1), 32'h1);
		check(c0_cnt - c0b, 32'h1);
		check(c1_cnt - c1b, 32'h1);
		$display("test width done");
		// Event counting, first while disabled
		wr(TCC_OFS_RUN, 32'h0);
		wr(TCC_OFS_MODE, 32'h030);
		wr(TCC_OFS_ENABLE, 32'h0);
		wr(TCC_OFS_RUN, 32'h5);
		repeat (3) src.pulse(3, 3);
		rchk(TCC_OFS_COUNT, 32'h0);
		wr(TCC_OFS_ENABLE, 32'h1);
		w = 1 + ($random(seed) & 7);
		a = 1 + ($random(seed) & 7);
		repeat (w) src.pulse(3, 3);
		src.set_peer(1'h1);
		repeat (a) src.pulse(3, 3);
		src.set_peer(1'h0);
		rchk(TCC_OFS_CAP0, 32'(w));
		rchk(TCC_OFS_CAP1, 32'(w + a));
		rchk(TCC_OFS_COUNT, 32'(w + a));
		$display("test events done");
		report_and_stop();
	end
endmodule
